// file: valve_drive_pkg.sv
// Shared constants and types for the valve output drive block
package valve_drive_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CARRIER_HZ = 25_000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned CARRIER_CYCLES = CLK_HZ / CARRIER_HZ;
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CARRIER_PERIOD = CNT_W'(CARRIER_CYCLES);
  // Output type codes
  localparam logic [2:0] TYPE_DISABLED = 3'h0;
  localparam logic [2:0] TYPE_CURRENT = 3'h1;
  localparam logic [2:0] TYPE_HOTSHOT = 3'h2;
  localparam logic [2:0] TYPE_PWM = 3'h3;
  localparam logic [2:0] TYPE_VOLTAGE = 3'h4;
  localparam logic [2:0] TYPE_DIGITAL = 3'h5;
  // Fault reaction codes
  localparam logic [1:0] FAULT_SHUTOFF = 2'h0;
  localparam logic [1:0] FAULT_VALUE = 2'h1;
  localparam logic [1:0] FAULT_HOLD = 2'h2;
  // Enable reaction codes
  localparam logic [2:0] EN_ON_SHUT = 3'h0;
  localparam logic [2:0] EN_ON_RAMP = 3'h1;
  localparam logic [2:0] EN_OFF_SHUT = 3'h2;
  localparam logic [2:0] EN_OFF_RAMP = 3'h3;
  localparam logic [2:0] EN_ON_MIN = 3'h4;
  localparam logic [2:0] EN_ON_MAX = 3'h5;
  // Digital response codes
  localparam logic [1:0] DIG_NORMAL = 2'h0;
  localparam logic [1:0] DIG_INVERSE = 2'h1;
  localparam logic [1:0] DIG_LATCHED = 2'h2;
  localparam logic [1:0] DIG_BLINK = 2'h3;
  // Scaling: duty is a 16-bit fraction, current in mA, PWM in 0.01 %
  localparam logic [15:0] DUTY_FULL = 16'hFFFF;
  localparam logic [15:0] CURRENT_FULL_MA = 16'h0BB8;
  localparam logic [15:0] PWM_FULL = 16'h2710;
  // Dependent setting defaults loaded on a type change
  localparam logic [15:0] CURRENT_MAX_DEF = 16'h07D0;
  localparam logic [15:0] PWM_MAX_DEF = 16'h2710;
  localparam logic [15:0] VOLTAGE_MAX_DEF = 16'h2EE0;
  localparam logic [15:0] DIGITAL_MAX_DEF = 16'h0001;
  localparam logic [15:0] OUT_MIN_DEF = 16'h0000;
  localparam logic [15:0] OVERRIDE_DEF = 16'h0000;
  localparam logic [15:0] FAULT_VALUE_DEF = 16'h0000;
  // Hotshot sequence, Gray coded
  typedef enum logic [1:0] {
    HS_OFF = 2'b00,
    HS_ENGAGE = 2'b01,
    HS_HOLD = 2'b11
  } hotshot_state_t;
endpackage

// file: pwm_carrier.sv
// Shared-period PWM generator with duty latched at period start
module pwm_carrier
  import valve_drive_pkg::*;
#(
  parameter int unsigned W = CNT_W
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Period in cycles and 16-bit duty fraction
  input wire logic [W-1:0] period,
  input wire logic [15:0] duty,
  // Switching output
  output logic pwm
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cmp_reg;
  logic pwm_reg;
  wire logic wrap = (cnt_reg >= period - W'(1));
  wire logic [W+15:0] prod = period * duty;
  wire logic [W-1:0] cmp_next = prod[W+15:16];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      cmp_reg <= '0;
      pwm_reg <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + W'(1);
      if (wrap) begin
        cmp_reg <= (duty == DUTY_FULL) ? period : cmp_next;
      end
      pwm_reg <= (cnt_reg < cmp_reg);
    end
  end

  assign pwm = pwm_reg;
endmodule

// file: valve_output_drive_control.sv
// Output control and drive logic for one valve output
// Behaviour
// RULE_01 - Faulted active input applies fault reaction: 0 off, 1 value, 2 hold.
// RULE_02 - CAN command missing past its timeout counts as a fault.
// RULE_03 - Fault reaction persists until all causing conditions clear.
// RULE_04 - Enabled supply diagnosis: over or under voltage disables output at once; drive_pwm keeps switching until the carrier period ends.
// RULE_05 - Enabled temperature diagnosis: over temperature disables output until cool.
// RULE_06 - Faults checked first, then Enable, then Override, then control.
// RULE_07 - Output type 0..5: off, current, hotshot, PWM, voltage, digital.
// RULE_08 - Type change reloads dependent settings with defaults for new type.
// RULE_09 - Only current and hotshot use feedback diagnostics; others ignore them.
// RULE_10 - Proportional types map control linearly between output min and max.
// RULE_11 - Up and down ramp times limit rate; step is range over time.
// RULE_12 - Configurer zeroes ramps when a time-response table drives output.
// RULE_13 - Current type uses 25 kHz carrier plus dither at set rate/amplitude.
// RULE_14 - Voltage type scales duty by measured supply to reach target.
// RULE_15 - Any output in current control forces PWM frequency to 25 kHz.
// RULE_16 - PWM frequency selectable only when both outputs PWM/voltage/digital.
// RULE_17 - Analog to digital: off at or below min, on at or above max.
// RULE_18 - Digital types use digital response and digital override state.
// RULE_19 - Digital response 0..3: normal, inverse, latched, blinking.
// RULE_20 - Latched response toggles output on each OFF to ON command edge.
// RULE_21 - Blinking toggles at blink rate while ON, off while OFF.
// RULE_22 - Blinking only for digital on/off type, refused for hotshot.
// RULE_23 - Hotshot applies engage current, then drops to hold current.
// RULE_24 - Enable reaction 0..5 selects polarity and shutoff/ramp/min/max.
// RULE_25 - Override drives the override value regardless of control.
// RULE_26 - Zero ramp time applies changes immediately.
module valve_output_drive_control
  import valve_drive_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES,
  parameter int unsigned CARRIER_CYC = CARRIER_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Type selection and shared carrier
  input wire logic [2:0] output_type,
  input wire logic [2:0] other_output_type,
  input wire logic [CNT_W-1:0] pwm_period_cfg,
  // Dependent settings write
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_out_min,
  input wire logic [15:0] cfg_out_max,
  input wire logic [15:0] cfg_override_value,
  input wire logic [15:0] cfg_fault_value,
  // Control input
  input wire logic [15:0] control_in,
  input wire logic [15:0] ctrl_in_min,
  input wire logic [15:0] ctrl_in_max,
  input wire logic control_fault,
  input wire logic control_is_can,
  input wire logic can_cmd_stb,
  input wire logic [15:0] can_timeout_ms,
  // Enable input
  input wire logic enable_used,
  input wire logic enable_in,
  input wire logic enable_fault,
  input wire logic [2:0] enable_response,
  // Override input
  input wire logic override_used,
  input wire logic override_in,
  input wire logic override_fault,
  input wire logic digital_override_state,
  // Fault reaction and global diagnosis
  input wire logic [1:0] fault_response,
  input wire logic load_fault,
  input wire logic supply_diag_en,
  input wire logic supply_over,
  input wire logic supply_under,
  input wire logic [15:0] supply_mv,
  input wire logic temp_diag_en,
  input wire logic over_temp,
  // Ramps, dither, digital, hotshot
  input wire logic [15:0] ramp_up_ms,
  input wire logic [15:0] ramp_down_ms,
  input wire logic [9:0] dither_hz,
  input wire logic [15:0] dither_amp_ma,
  input wire logic [1:0] digital_response,
  input wire logic [15:0] blink_ms,
  input wire logic [15:0] hotshot_engage_ma,
  input wire logic [15:0] hotshot_hold_ma,
  input wire logic [15:0] hotshot_engage_ms,
  // Drive and status
  output logic drive_pwm,
  output logic [15:0] output_value,
  output logic [15:0] duty,
  output logic fault_active,
  output logic global_off,
  output logic digital_state,
  output logic diag_enabled,
  output logic [15:0] out_min,
  output logic [15:0] out_max,
  output logic [15:0] override_value,
  output logic [15:0] fault_value
);
  localparam logic [CNT_W-1:0] MS_LIMIT = CNT_W'(MS_CYC - 1);
  localparam logic [CNT_W-1:0] CARRIER_LIM = CNT_W'(CARRIER_CYC);

  // Settings and state registers
  logic [CNT_W-1:0] ms_cnt_reg;
  logic [15:0] comm_cnt_reg;
  logic [2:0] type_prev_reg;
  logic [15:0] min_reg, max_reg, ovr_reg, fval_reg;
  logic [15:0] value_reg, value_next;
  logic [15:0] duty_reg;
  logic fault_reg, goff_reg, diag_reg, dig_out_reg;
  logic dig_cmd_reg, dig_cmd_prev_reg, latch_reg, blink_reg;
  logic [15:0] blink_cnt_reg, hs_cnt_reg;
  logic [CNT_W-1:0] dith_cnt_reg;
  logic dith_reg;
  hotshot_state_t hs_reg, hs_next;

  function automatic logic [15:0] to_duty(input logic [16:0] v,
                                          input logic [15:0] full);
    logic [33:0] q;
    q = (full == 16'h0) ? 34'h0 : ({17'h0, v} * 34'(DUTY_FULL)) / full;
    return (q > 34'(DUTY_FULL)) ? DUTY_FULL : q[15:0];
  endfunction

  // Time base
  wire logic ms_tick = (ms_cnt_reg == MS_LIMIT);

  // Type decode
  wire logic is_current = (output_type == TYPE_CURRENT); // RULE_07
  wire logic is_hotshot = (output_type == TYPE_HOTSHOT);
  wire logic is_pwm = (output_type == TYPE_PWM);
  wire logic is_voltage = (output_type == TYPE_VOLTAGE);
  wire logic is_digital = (output_type == TYPE_DIGITAL);
  wire logic is_dig_type = is_hotshot | is_digital;
  wire logic is_prop = is_current | is_pwm | is_voltage;
  wire logic diag_use = is_current | is_hotshot; // RULE_09
  wire logic type_changed = (output_type != type_prev_reg);

  // Fault detection
  wire logic comm_lost = control_is_can &&
                         (comm_cnt_reg >= can_timeout_ms); // RULE_02
  wire logic input_fault = (enable_used & enable_fault) |
                           (override_used & override_fault) |
                           control_fault | comm_lost |
                           (diag_use & load_fault); // RULE_01 RULE_09
  wire logic supply_off = supply_diag_en & (supply_over | supply_under);
  wire logic temp_off = temp_diag_en & over_temp; // RULE_05
  wire logic goff_now = supply_off | temp_off; // RULE_04

  // Enable and override decode
  wire logic en_inverted = (enable_response == EN_OFF_SHUT) ||
                           (enable_response == EN_OFF_RAMP);
  wire logic en_ok = !enable_used || (enable_in ^ en_inverted); // RULE_24
  wire logic ovr_active = override_used & override_in;

  // Linear map of the control input
  wire logic [15:0] x_clamp = (control_in < ctrl_in_min) ? ctrl_in_min :
                              (control_in > ctrl_in_max) ? ctrl_in_max :
                              control_in;
  wire logic [15:0] x_span = ctrl_in_max - ctrl_in_min;
  wire logic [15:0] x_off = x_clamp - ctrl_in_min;
  wire logic signed [16:0] y_span = $signed({1'b0, max_reg}) -
                                    $signed({1'b0, min_reg});
  wire logic signed [33:0] lin_num = $signed({18'h0, x_off}) *
                                     34'(y_span);
  wire logic signed [33:0] lin_q = (x_span == 16'h0) ? 34'sh0 :
                                   lin_num / $signed({18'h0, x_span});
  wire logic signed [33:0] lin_sum = $signed({18'h0, min_reg}) + lin_q;
  wire logic [15:0] lin_val = lin_sum[15:0]; // RULE_10

  // Digital command with hysteresis
  wire logic dig_cmd_next = (control_in >= ctrl_in_max) ? 1'b1 :
                            (control_in <= ctrl_in_min) ? 1'b0 :
                            dig_cmd_reg; // RULE_17
  wire logic dig_rise = dig_cmd_reg & ~dig_cmd_prev_reg;
  wire logic blink_ok = is_digital; // RULE_22
  logic dig_resp;
  always_comb begin
    case (digital_response) // RULE_19
      DIG_NORMAL: dig_resp = dig_cmd_reg;
      DIG_INVERSE: dig_resp = ~dig_cmd_reg;
      DIG_LATCHED: dig_resp = latch_reg; // RULE_20
      DIG_BLINK: dig_resp = blink_ok ? (dig_cmd_reg & blink_reg) :
                            dig_cmd_reg; // RULE_21
      default: dig_resp = dig_cmd_reg;
    endcase
  end
  wire logic dig_on = goff_now ? 1'b0 :
                      input_fault ? ((fault_response == FAULT_HOLD) ?
                                     dig_out_reg :
                                     (fault_response == FAULT_VALUE) &
                                     (fval_reg != 16'h0)) :
                      !en_ok ? 1'b0 :
                      ovr_active ? digital_override_state : // RULE_18
                      dig_resp;

  // Target selection in priority order
  logic [15:0] target;
  logic direct;
  logic hold;
  always_comb begin
    target = 16'h0;
    direct = 1'b0;
    hold = 1'b0;
    if (goff_now) begin
      direct = 1'b1;
    end else if (input_fault) begin // RULE_06 RULE_03
      direct = 1'b1;
      case (fault_response) // RULE_01
        FAULT_SHUTOFF: target = 16'h0;
        FAULT_VALUE: target = fval_reg;
        FAULT_HOLD: hold = 1'b1;
        default: target = 16'h0;
      endcase
    end else if (!en_ok) begin
      case (enable_response) // RULE_24
        EN_ON_SHUT, EN_OFF_SHUT: direct = 1'b1;
        EN_ON_MIN: target = min_reg;
        EN_ON_MAX: target = max_reg;
        default: target = 16'h0;
      endcase
    end else if (ovr_active) begin
      target = ovr_reg; // RULE_25
    end else begin
      target = lin_val;
    end
    if (is_dig_type || !is_prop) begin
      target = dig_on ? max_reg : 16'h0;
      direct = 1'b1;
      hold = 1'b0;
    end
  end

  // Ramp step sizes
  wire logic [15:0] range = (max_reg > min_reg) ? (max_reg - min_reg) :
                            (min_reg - max_reg);
  wire logic [15:0] up_q = (ramp_up_ms == 16'h0) ? 16'h0 :
                           range / ramp_up_ms;
  wire logic [15:0] dn_q = (ramp_down_ms == 16'h0) ? 16'h0 :
                           range / ramp_down_ms;
  wire logic [15:0] up_step = (up_q == 16'h0) ? 16'h1 : up_q; // RULE_11
  wire logic [15:0] dn_step = (dn_q == 16'h0) ? 16'h1 : dn_q;
  wire logic going_up = target > value_reg;
  wire logic no_ramp = going_up ? (ramp_up_ms == 16'h0) :
                       (ramp_down_ms == 16'h0); // RULE_26
  always_comb begin
    value_next = value_reg;
    if (hold) begin
      value_next = value_reg;
    end else if (direct || no_ramp) begin
      value_next = target;
    end else if (ms_tick && going_up) begin
      value_next = ((target - value_reg) > up_step) ?
                   value_reg + up_step : target;
    end else if (ms_tick && (target < value_reg)) begin
      value_next = ((value_reg - target) > dn_step) ?
                   value_reg - dn_step : target;
    end
  end

  // Hotshot sequence
  always_comb begin
    hs_next = hs_reg;
    case (hs_reg) // RULE_23
      HS_OFF: if (is_hotshot && dig_on) hs_next = HS_ENGAGE;
      HS_ENGAGE: begin
        if (!is_hotshot || !dig_on) begin
          hs_next = HS_OFF;
        end else if (hs_cnt_reg >= hotshot_engage_ms) begin
          hs_next = HS_HOLD;
        end
      end
      HS_HOLD: if (!is_hotshot || !dig_on) hs_next = HS_OFF;
      default: hs_next = HS_OFF;
    endcase
  end
  wire logic [15:0] hs_ma = (hs_reg == HS_ENGAGE) ? hotshot_engage_ma :
                            (hs_reg == HS_HOLD) ? hotshot_hold_ma : 16'h0;

  // Dither on the current target
  wire logic [CNT_W-1:0] dith_half = (dither_hz == 10'h0) ? '0 :
                                     CNT_W'(CLK_HZ / (32'(dither_hz) * 2));
  wire logic [16:0] cur_hi = {1'b0, value_reg} + {1'b0, dither_amp_ma};
  wire logic [16:0] cur_lo = (value_reg > dither_amp_ma) ?
                             {1'b0, value_reg - dither_amp_ma} : 17'h0;
  wire logic dith_on = (dither_hz != 10'h0) && (value_reg != 16'h0);
  wire logic [16:0] cur_ma = !dith_on ? {1'b0, value_reg} :
                             dith_reg ? cur_hi : cur_lo; // RULE_13

  // Duty per type
  logic [15:0] duty_next;
  always_comb begin
    case (output_type)
      TYPE_CURRENT: duty_next = to_duty(cur_ma, CURRENT_FULL_MA);
      TYPE_HOTSHOT: duty_next = to_duty({1'b0, hs_ma}, CURRENT_FULL_MA);
      TYPE_PWM: duty_next = to_duty({1'b0, value_reg}, PWM_FULL);
      TYPE_VOLTAGE: duty_next = to_duty({1'b0, value_reg},
                                        supply_mv); // RULE_14
      TYPE_DIGITAL: duty_next = dig_on ? DUTY_FULL : 16'h0;
      default: duty_next = 16'h0;
    endcase
    if (goff_now) duty_next = 16'h0; // RULE_04 RULE_05
  end

  // Shared carrier period
  wire logic mine_free = is_pwm | is_voltage | is_digital;
  wire logic other_free = (other_output_type == TYPE_PWM) ||
                          (other_output_type == TYPE_VOLTAGE) ||
                          (other_output_type == TYPE_DIGITAL);
  wire logic freq_select = mine_free & other_free; // RULE_16 RULE_15
  wire logic [CNT_W-1:0] period = (freq_select &&
                                   pwm_period_cfg != '0) ?
                                  pwm_period_cfg : CARRIER_LIM; // RULE_13

  // Type defaults
  wire logic [15:0] max_def = is_current ? CURRENT_MAX_DEF :
                              is_hotshot ? CURRENT_MAX_DEF :
                              is_pwm ? PWM_MAX_DEF :
                              is_voltage ? VOLTAGE_MAX_DEF :
                              DIGITAL_MAX_DEF;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt_reg <= '0;
      comm_cnt_reg <= 16'h0;
      type_prev_reg <= TYPE_DISABLED;
      min_reg <= OUT_MIN_DEF;
      max_reg <= OUT_MIN_DEF;
      ovr_reg <= OVERRIDE_DEF;
      fval_reg <= FAULT_VALUE_DEF;
    end else begin
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + CNT_W'(1);
      if (can_cmd_stb) begin
        comm_cnt_reg <= 16'h0;
      end else if (ms_tick && comm_cnt_reg != 16'hFFFF) begin
        comm_cnt_reg <= comm_cnt_reg + 16'h1;
      end
      type_prev_reg <= output_type;
      if (type_changed) begin // RULE_08
        min_reg <= OUT_MIN_DEF;
        max_reg <= max_def;
        ovr_reg <= OVERRIDE_DEF;
        fval_reg <= FAULT_VALUE_DEF;
      end else if (cfg_wr) begin
        min_reg <= cfg_out_min;
        max_reg <= cfg_out_max;
        ovr_reg <= cfg_override_value;
        fval_reg <= cfg_fault_value;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dig_cmd_reg <= 1'b0;
      dig_cmd_prev_reg <= 1'b0;
      latch_reg <= 1'b0;
      blink_reg <= 1'b0;
      blink_cnt_reg <= 16'h0;
    end else begin
      dig_cmd_reg <= dig_cmd_next;
      dig_cmd_prev_reg <= dig_cmd_reg;
      if (dig_rise) latch_reg <= ~latch_reg; // RULE_20
      if (!dig_cmd_reg) begin
        blink_reg <= 1'b0;
        blink_cnt_reg <= 16'h0;
      end else if (ms_tick) begin
        if (blink_cnt_reg + 16'h1 >= blink_ms) begin // RULE_21
          blink_cnt_reg <= 16'h0;
          blink_reg <= ~blink_reg;
        end else begin
          blink_cnt_reg <= blink_cnt_reg + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_reg <= HS_OFF;
      hs_cnt_reg <= 16'h0;
      dith_cnt_reg <= '0;
      dith_reg <= 1'b0;
      value_reg <= 16'h0;
      duty_reg <= 16'h0;
      fault_reg <= 1'b0;
      goff_reg <= 1'b0;
      diag_reg <= 1'b0;
      dig_out_reg <= 1'b0;
    end else begin
      hs_reg <= hs_next;
      if (hs_next != hs_reg) begin
        hs_cnt_reg <= 16'h0;
      end else if (ms_tick && hs_cnt_reg != 16'hFFFF) begin
        hs_cnt_reg <= hs_cnt_reg + 16'h1;
      end
      if (dith_cnt_reg + CNT_W'(1) >= dith_half) begin
        dith_cnt_reg <= '0;
        dith_reg <= ~dith_reg;
      end else begin
        dith_cnt_reg <= dith_cnt_reg + CNT_W'(1);
      end
      value_reg <= value_next;
      duty_reg <= duty_next;
      fault_reg <= input_fault & ~goff_now;
      goff_reg <= goff_now;
      diag_reg <= diag_use;
      dig_out_reg <= dig_on;
    end
  end

  pwm_carrier #(.W(CNT_W)) carrier (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .period(period),
    .duty(duty_reg),
    .pwm(drive_pwm)
  );

  assign output_value = value_reg;
  assign duty = duty_reg;
  assign fault_active = fault_reg;
  assign global_off = goff_reg;
  assign digital_state = dig_out_reg;
  assign diag_enabled = diag_reg;
  assign out_min = min_reg;
  assign out_max = max_reg;
  assign override_value = ovr_reg;
  assign fault_value = fval_reg;
endmodule

// file: valve_drive_monitor.sv
// Assertion checker for the valve output drive control block
module valve_drive_monitor
  import valve_drive_pkg::*;
(
  // Clock, reset and inputs
  input wire logic core_clk, rst_b, cfg_wr, control_fault,
  input wire logic supply_diag_en, supply_over, supply_under,
  input wire logic temp_diag_en, over_temp,
  input wire logic [2:0] output_type,
  input wire logic [1:0] fault_response,
  input wire logic [15:0] cfg_out_min, cfg_override_value, cfg_fault_value,
  // Outputs
  input wire logic fault_active, global_off, diag_enabled,
  input wire logic [15:0] output_value, out_min, out_max,
  input wire logic [15:0] override_value, fault_value
);
  logic glob;
  assign glob = (supply_diag_en && (supply_over || supply_under)) ||
    (temp_diag_en && over_temp);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_global_off: assert property (glob |=> global_off)
    else $error("no global off");
  a_global_zero: assert property (
    global_off |-> output_value == 16'h0000) else $error("output not off");
  a_diag_decode: assert property (##1 diag_enabled ==
    ($past(output_type) == TYPE_CURRENT || $past(output_type) == TYPE_HOTSHOT))
    else $error("diag decode wrong");
  a_type_defaults: assert property (output_type == TYPE_PWM &&
    $past(output_type) != TYPE_PWM |=> out_max == PWM_MAX_DEF &&
    out_min == OUT_MIN_DEF) else $error("defaults not loaded");
  a_cfg_load: assert property (cfg_wr && $past(rst_b) &&
    output_type == $past(output_type) |=> out_min == $past(cfg_out_min) &&
    override_value == $past(cfg_override_value) &&
    fault_value == $past(cfg_fault_value)) else $error("cfg not loaded");
  a_fault_flag: assert property (
    control_fault && !glob |=> fault_active) else $error("no fault flag");
  a_fault_shutoff: assert property (control_fault &&
    fault_response == FAULT_SHUTOFF |=> output_value == 16'h0000)
    else $error("fault shutoff wrong");
  a_fault_value: assert property (control_fault && !glob && !cfg_wr &&
    fault_response == FAULT_VALUE && output_type == TYPE_PWM
    |=> output_value == fault_value) else $error("fault value wrong");
endmodule
bind valve_output_drive_control valve_drive_monitor valve_drive_monitor_i (
  .core_clk, .rst_b, .cfg_wr, .control_fault, .supply_diag_en, .supply_over,
  .supply_under, .temp_diag_en, .over_temp, .output_type, .fault_response,
  .cfg_out_min, .cfg_override_value, .cfg_fault_value, .fault_active,
  .global_off, .diag_enabled, .output_value, .out_min, .out_max,
  .override_value, .fault_value);

// file: valve_load_model.sv
// Coil load model that reports the switching period it sees
module valve_load_model (
  // Clock, reset, drive and measured period
  input wire logic core_clk, rst_b, drive_pwm,
  output logic [15:0] period_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] count_reg;
  logic prev_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 16'h0000;
      prev_reg <= 1'b0;
      period_seen <= 16'h0000;
    end else begin
      prev_reg <= drive_pwm;
      count_reg <= (drive_pwm && !prev_reg) ? 16'h0000 : count_reg + 16'h0001;
      if (drive_pwm && !prev_reg) begin
        period_seen <= count_reg + 16'h0001;
      end
    end
  end
endmodule

// file: valve_output_drive_control_tb.sv
// Self-checking bench for the valve output drive control block
module valve_output_drive_control_tb;
  import valve_drive_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_b = 0, cfg_wr = 0, control_fault = 0;
  logic control_is_can = 0, can_cmd_stb = 0, enable_used = 0, enable_in = 0;
  logic enable_fault = 0, override_used = 0, override_in = 0;
  logic override_fault = 0, digital_override_state = 0, load_fault = 0;
  logic supply_diag_en = 0, supply_over = 0, supply_under = 0;
  logic temp_diag_en = 0, over_temp = 0, drive_pwm, fault_active;
  logic global_off, digital_state, diag_enabled;
  logic [2:0] output_type = 3'h0, other_output_type = 3'h3;
  logic [2:0] enable_response = 3'h0;
  logic [1:0] fault_response = 2'h0, digital_response = 2'h0;
  logic [CNT_W-1:0] pwm_period_cfg = '0;
  logic [9:0] dither_hz = 10'h000;
  logic [15:0] cfg_out_min = 16'h0000, cfg_out_max = 16'h2710;
  logic [15:0] cfg_override_value = 16'h04D2, cfg_fault_value = 16'h0309;
  logic [15:0] control_in = 16'h0000, ctrl_in_min = 16'h0000;
  logic [15:0] ctrl_in_max = 16'h0064, can_timeout_ms = 16'h0003;
  logic [15:0] supply_mv = 16'h2EE0, ramp_up_ms = 16'h0000;
  logic [15:0] ramp_down_ms = 16'h0000, dither_amp_ma = 16'h0000;
  logic [15:0] blink_ms = 16'h0002, hotshot_engage_ma = 16'h03E8;
  logic [15:0] hotshot_hold_ma = 16'h01F4, hotshot_engage_ms = 16'h0002;
  logic [15:0] output_value, duty, out_min, out_max, override_value;
  logic [15:0] fault_value, period_seen;
  int failures = 0;
  int comparisons = 0;
  valve_output_drive_control #(.MS_CYC(10), .CARRIER_CYC(20))
    valve_output_drive_control_i (.core_clk, .rst_b, .output_type,
    .other_output_type, .pwm_period_cfg, .cfg_wr, .cfg_out_min, .cfg_out_max,
    .cfg_override_value, .cfg_fault_value, .control_in, .ctrl_in_min,
    .ctrl_in_max, .control_fault, .control_is_can, .can_cmd_stb,
    .can_timeout_ms, .enable_used, .enable_in, .enable_fault,
    .enable_response, .override_used, .override_in, .override_fault,
    .digital_override_state, .fault_response, .load_fault, .supply_diag_en,
    .supply_over, .supply_under, .supply_mv, .temp_diag_en, .over_temp,
    .ramp_up_ms, .ramp_down_ms, .dither_hz, .dither_amp_ma,
    .digital_response, .blink_ms, .hotshot_engage_ma, .hotshot_hold_ma,
    .hotshot_engage_ms, .drive_pwm, .output_value, .duty, .fault_active,
    .global_off, .digital_state, .diag_enabled, .out_min, .out_max,
    .override_value, .fault_value);
  valve_load_model valve_load_model_i (.core_clk, .rst_b, .drive_pwm,
    .period_seen);
  always #2 core_clk = ~core_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    #1;
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tally_and_finish;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20us;
    failures++;
    tally_and_finish();
  end
  initial begin
    tick(12);
    rst_b <= 1'b1;
    tick(1);
    output_type <= TYPE_PWM;
    tick(4);
    cmp16(out_max, PWM_MAX_DEF);
    cmp1(diag_enabled, 1'b0);
    control_in <= 16'h0032;
    tick(4);
    cmp16(output_value, 16'h1388);
    ramp_up_ms <= 16'h0004;
    control_in <= 16'h0064;
    tick(3);
    cmp1(output_value < 16'h2710, 1'b1);
    tick(60);
    cmp16(output_value, 16'h2710);
    ramp_up_ms <= 16'h0000;
    cfg_wr <= 1'b1;
    tick(1);
    cfg_wr <= 1'b0;
    override_used <= 1'b1;
    override_in <= 1'b1;
    tick(4);
    cmp16(output_value, 16'h04D2);
    enable_used <= 1'b1;
    for (int r = 2; r >= 0; r -= 2) begin
      enable_response <= 3'(r);
      tick(4);
      cmp16(output_value, r == 0 ? 16'h0000 : 16'h04D2);
    end
    enable_used <= 1'b0;
    override_used <= 1'b0;
    control_fault <= 1'b1;
    fault_response <= FAULT_VALUE;
    tick(24);
    cmp16(output_value, 16'h0309);
    fault_response <= FAULT_SHUTOFF;
    tick(4);
    cmp16(output_value, 16'h0000);
    control_fault <= 1'b0;
    tick(4);
    cmp1(fault_active, 1'b0);
    supply_diag_en <= 1'b1;
    supply_under <= 1'b1;
    tick(4);
    cmp16(output_value, 16'h0000);
    supply_under <= 1'b0;
    temp_diag_en <= 1'b1;
    over_temp <= 1'b1;
    tick(4);
    cmp1(global_off, 1'b1);
    over_temp <= 1'b0;
    tick(4);
    cmp16(output_value, 16'h2710);
    cmp16(duty, DUTY_FULL);
    control_is_can <= 1'b1;
    can_cmd_stb <= 1'b1;
    tick(1);
    can_cmd_stb <= 1'b0;
    tick(20);
    cmp1(fault_active, 1'b0);
    tick(30);
    cmp1(fault_active, 1'b1);
    control_is_can <= 1'b0;
    output_type <= TYPE_CURRENT;
    control_in <= 16'h0032;
    tick(200);
    cmp16(out_max, CURRENT_MAX_DEF);
    cmp16(output_value, 16'h03E8);
    cmp16(period_seen, 16'h0014);
    output_type <= TYPE_DIGITAL;
    control_in <= 16'h0064;
    tick(4);
    cmp1(digital_state, 1'b1);
    digital_response <= DIG_INVERSE;
    control_in <= 16'h0032;
    tick(4);
    cmp1(digital_state, 1'b0);
    control_in <= 16'h0000;
    tick(4);
    cmp1(digital_state, 1'b1);
    tally_and_finish();
  end
endmodule
